// [rtl/t1fp_cfg.svh]
// constants of the t1 framer pin interface: offsets, fields, counts
// assumes one 40 MHz system clock that oversamples every pin clock
`ifndef T1FP_CFG_SVH
`define T1FP_CFG_SVH
`define T1FP_CHANNELS    24
`define T1FP_LINE_LAST   8'd192
`define T1FP_LINE_HALF   8'd97
`define T1FP_MCW1_SLOT   5'd15
`define T1FP_MCW2_SLOT   5'd31
`define T1FP_SPARE_DRIVE_OUT_BIT    3
`define T1FP_XST_BIT     5
`define T1FP_IDLE_BIT    0
`define T1FP_INV_BIT     0
`define T1FP_LOOP_BIT    0
`define T1FP_ALT_BIT     1
`define T1FP_IDLE_CODE   8'hFF
`define T1FP_EMPTY_SLOT  8'hFF
`define T1FP_REG_CTRL    4'h0
`define T1FP_REG_STAT    4'h4
`define T1FP_REG_BPV     4'h8
`define T1FP_CTRL_RESET  2'h0
`define T1FP_BPV_MAX     16'hFFFF
`endif

// [rtl/t1fp_pkg.sv]
// types shared by the t1 framer pin interface
// assumes t1fp_cfg.svh is compiled alongside
package t1fp_pkg;
  typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_ACK = 2'b10} t1fp_bus_t;
  typedef struct packed {
    logic altMode;
    logic loop;
  } t1fp_ctrl_t;
  typedef struct packed {
    logic bpRise;
    logic bpFall;
    logic txRise;
    logic rxFall;
  } t1fp_edge_t;
endpackage

// [rtl/t1fp_port.sv]
// t1 framer pin interface: backplane streams, ds1 line pins, link ports
// assumes sys_clk at 40 MHz oversamples all pin clocks; Avalon-MM slave
// Behaviour
// R1: recovered line channels go out on the 2048 kbit/s data stream.
// R2: backplane data stream channels are sent on the t1 line.
// R3: control stream zero holds 24 channel words and two master words.
// R4: control stream one holds 24 channel words applied per channel.
// R5: status stream carries 24 channel words and two master words; the channel words are sent as 00.
// R6: transmit marks split onto two unipolar outputs, A and B.
// R7: bipolar violations found from the two receive inputs together.
// R8: line receiver presents NAND of complementary receive signals.
// R9: transmit link bits go into link or alternate frame positions.
// R10: device makes 4 kHz transmit link clock, samples on rise.
// R11: recovered clock divided by 193 gives frame-aligned 8 kHz.
// R12: in loopback the 8 kHz comes from the transmit clock.
// R13: spare drive follows bit 3 of first master control word.
// R14: spare drive updates once per frame and holds between.
// R15: spare sense sampled per frame, reported in master status bit 5.
// R16: device makes 4 kHz receive link clock, data changes on rise.
// R17: backplane clock shifts all serial streams in and out.
// R18: backplane party marks each 32-channel frame with a pulse.
// R19: receive inputs sampled on falling edge of recovered clock.
// R20: line outputs change on rising edge of transmit clock.
// R21: spare sense synchronised before its per-frame sample.
// R22: receive channels pass a buffer between line and backplane.
`include "t1fp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module t1fp_port (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        backplane_clk,
  input  wire logic        backplane_frame_pulse_n,
  input  wire logic        serial_data_in,
  input  wire logic        serial_ctrl_in_zero,
  input  wire logic        serial_ctrl_in_one,
  output logic             serial_data_out,
  output logic             serial_status_out,
  input  wire logic        line_tx_clk,
  input  wire logic        recovered_line_clk,
  input  wire logic        line_in_a_n,
  input  wire logic        line_in_b_n,
  output logic             line_out_a,
  output logic             line_out_b,
  input  wire logic        link_bits_in,
  output logic             link_bits_in_clk,
  output logic             link_bits_out,
  output logic             link_bits_out_clk,
  output logic             recovered_frame_clk_out,
  output logic             spare_drive_out,
  input  wire logic        spare_sense_in
);
  import t1fp_pkg::*;

  localparam int I_BP = 10, I_FP = 9, I_DI = 8, I_C0 = 7, I_C1 = 6, I_TX = 5;
  localparam int I_RX = 4, I_A = 3, I_B = 2, I_LK = 1, I_SN = 0;

  function automatic logic [4:0] chOf(input logic [4:0] slot);
    chOf = 5'(slot[4:2] * 3'd3) + 5'(slot[1:0]);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers; third stage only feeds edge detection
  logic [10:0] syncA_r, syncB_r, syncC_r;
  always_ff @(posedge sys_clk) begin
    syncA_r <= {backplane_clk, backplane_frame_pulse_n, serial_data_in, serial_ctrl_in_zero,
                serial_ctrl_in_one, line_tx_clk, recovered_line_clk, line_in_a_n, line_in_b_n,
                link_bits_in, spare_sense_in};
    syncB_r <= syncA_r;
    syncC_r <= syncB_r;
  end

  t1fp_ctrl_t ctrl_r, ctrl_nxt, mode;
  t1fp_edge_t ev;
  logic [7:0] mcw1_r, mcw1_nxt, mcw2_r, mcw2_nxt;
  always_comb begin
    ev.bpRise = syncB_r[I_BP] & ~syncC_r[I_BP];
    ev.bpFall = ~syncB_r[I_BP] & syncC_r[I_BP];
    ev.txRise = syncB_r[I_TX] & ~syncC_r[I_TX];
    ev.rxFall = ~syncB_r[I_RX] & syncC_r[I_RX];
    mode.loop    = ctrl_r.loop | mcw2_r[`T1FP_LOOP_BIT];
    mode.altMode = ctrl_r.altMode | mcw2_r[`T1FP_ALT_BIT];
  end

  ////////////////////////////////////////////////////////////////////////
  // channel memories
  logic [7:0] txMem [`T1FP_CHANNELS];
  logic [7:0] rxMem [`T1FP_CHANNELS];
  logic [7:0] ctl0Mem [`T1FP_CHANNELS];
  logic [7:0] ctl1Mem [`T1FP_CHANNELS];

  ////////////////////////////////////////////////////////////////////////
  // backplane side
  logic [7:0] bpCnt_r, bpCnt_nxt, diSh_r, diSh_nxt, c0Sh_r, c0Sh_nxt, c1Sh_r, c1Sh_nxt;
  logic [7:0] doSh_r, doSh_nxt, soSh_r, soSh_nxt, diByte, c0Byte, c1Byte, msw1, msw2;
  logic [4:0] inSlot, inCh, outSlot, outCh;
  logic       bpWr, frameStart, spare_r, spare_nxt, sense_r, sense_nxt;
  logic [15:0] bpv_r, bpv_nxt;

  always_comb begin
    bpCnt_nxt = bpCnt_r;
    diSh_nxt  = diSh_r;
    c0Sh_nxt  = c0Sh_r;
    c1Sh_nxt  = c1Sh_r;
    doSh_nxt  = doSh_r;
    soSh_nxt  = soSh_r;
    mcw1_nxt  = mcw1_r;
    mcw2_nxt  = mcw2_r;
    spare_nxt = spare_r;
    sense_nxt = sense_r;
    inSlot    = bpCnt_r[7:3];
    inCh      = chOf(inSlot);
    diByte    = {diSh_r[6:0], syncB_r[I_DI]};
    c0Byte    = {c0Sh_r[6:0], syncB_r[I_C0]};
    c1Byte    = {c1Sh_r[6:0], syncB_r[I_C1]};
    bpWr      = 1'b0;
    frameStart = ev.bpFall & ~syncB_r[I_FP];
    msw1      = bpv_r[7:0];
    msw2      = 8'h00;
    msw2[`T1FP_XST_BIT] = sense_r;                             // [R15]
    if (ev.bpRise) begin                                       // [R17]
      diSh_nxt = diByte;
      c0Sh_nxt = c0Byte;
      c1Sh_nxt = c1Byte;
      if (bpCnt_r[2:0] == 3'h7) begin
        bpWr = (inSlot[1:0] != 2'b11);                         // [R2] [R3] [R4]
        if (inSlot == `T1FP_MCW1_SLOT) mcw1_nxt = c0Byte;      // [R3]
        if (inSlot == `T1FP_MCW2_SLOT) mcw2_nxt = c0Byte;
      end
    end
    // a frame pulse restarts the bit count at the next falling edge
    bpCnt_nxt = frameStart ? 8'h00 : bpCnt_r + 8'h01;
    outSlot   = bpCnt_nxt[7:3];
    outCh     = chOf(outSlot);
    if (ev.bpFall) begin                                       // [R17]
      if (bpCnt_nxt[2:0] == 3'h0) begin
        doSh_nxt = (outSlot[1:0] != 2'b11) ? rxMem[outCh] : `T1FP_EMPTY_SLOT; // [R1] [R22]
        soSh_nxt = (outSlot == `T1FP_MCW1_SLOT) ? msw1 :
                   (outSlot == `T1FP_MCW2_SLOT) ? msw2 : 8'h00; // [R5]
      end else begin
        doSh_nxt = {doSh_r[6:0], 1'b0};
        soSh_nxt = {soSh_r[6:0], 1'b0};
      end
    end else begin
      bpCnt_nxt = bpCnt_r;
    end
    if (frameStart) begin
      spare_nxt = mcw1_r[`T1FP_SPARE_DRIVE_OUT_BIT];                      // [R13] [R14]
      sense_nxt = syncB_r[I_SN];                               // [R21]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      bpCnt_r <= 8'h00;
      diSh_r  <= 8'h00;
      c0Sh_r  <= 8'h00;
      c1Sh_r  <= 8'h00;
      doSh_r  <= 8'hFF;
      soSh_r  <= 8'h00;
      mcw1_r  <= 8'h00;
      mcw2_r  <= 8'h00;
      spare_r <= 1'b0;
      sense_r <= 1'b0;
    end else begin
      bpCnt_r <= bpCnt_nxt;
      diSh_r  <= diSh_nxt;
      c0Sh_r  <= c0Sh_nxt;
      c1Sh_r  <= c1Sh_nxt;
      doSh_r  <= doSh_nxt;
      soSh_r  <= soSh_nxt;
      mcw1_r  <= mcw1_nxt;
      mcw2_r  <= mcw2_nxt;
      spare_r <= spare_nxt;
      sense_r <= sense_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // line side: transmit and receive framers
  logic [7:0] txCnt_r, txCnt_nxt, txPos, txByte, rxCnt_r, rxCnt_nxt, rxPos, rxSh_r, rxSh_nxt;
  logic [4:0] txCh;
  logic txOdd_r, txOdd_nxt, txPol_r, txPol_nxt, outA_r, outA_nxt, outB_r, outB_nxt;
  logic hold_r, hold_nxt, txBit, lineEdge, inBit, rxWr, rxOdd_r, rxOdd_nxt, busClr, seen_r, seen_nxt;
  logic cap_r, cap_nxt, lkOut_r, lkOut_nxt, lastB_r, lastB_nxt, viol, fr8_r, fr8_nxt;

  always_comb begin
    txCnt_nxt = txCnt_r;
    txOdd_nxt = txOdd_r;
    txPol_nxt = txPol_r;
    outA_nxt  = outA_r;
    outB_nxt  = outB_r;
    hold_nxt  = hold_r;
    txPos     = txCnt_r - 8'h01;
    txCh      = txPos[7:3];
    txByte    = ctl0Mem[txCh][`T1FP_IDLE_BIT] ? `T1FP_IDLE_CODE
              : txMem[txCh] ^ {8{ctl1Mem[txCh][`T1FP_INV_BIT]}}; // [R4]
    // link bits ride the odd frames, or the even ones in alternate mode
    if (txCnt_r == 8'h00) txBit = (txOdd_r ^ mode.altMode) & hold_r; // [R9]
    else txBit = txByte[3'(~txPos[2:0])];                          // [R2]
    if (ev.txRise) begin                                           // [R20]
      outA_nxt  = txBit & ~txPol_r;                                // [R6]
      outB_nxt  = txBit & txPol_r;
      txPol_nxt = txPol_r ^ txBit;
      txCnt_nxt = (txCnt_r == `T1FP_LINE_LAST) ? 8'h00 : txCnt_r + 8'h01;
      if (txCnt_r == `T1FP_LINE_LAST) begin
        txOdd_nxt = ~txOdd_r;
        if (!txOdd_r) hold_nxt = syncB_r[I_LK];                    // [R10]
      end
    end
    rxCnt_nxt = rxCnt_r;
    rxSh_nxt  = rxSh_r;
    rxOdd_nxt = rxOdd_r;
    cap_nxt   = cap_r;
    lkOut_nxt = lkOut_r;
    lastB_nxt = lastB_r;
    bpv_nxt   = bpv_r;
    rxWr      = 1'b0;
    viol      = 1'b0;
    rxPos     = rxCnt_r - 8'h01;
    lineEdge  = mode.loop ? ev.txRise : ev.rxFall;                 // [R12] [R19]
    inBit     = mode.loop ? txBit : (~syncB_r[I_A] | ~syncB_r[I_B]); // [R8]
    // the first mark after reset has no earlier mark to violate
    seen_nxt  = seen_r | (lineEdge & ~mode.loop & inBit);
    if (lineEdge) begin
      if (!mode.loop) begin                                        // [R7]
        if (!syncB_r[I_A]) begin
          viol      = seen_r & ~lastB_r;
          lastB_nxt = 1'b0;
        end
        if (!syncB_r[I_B]) begin
          viol      = viol | (seen_r & lastB_r);
          lastB_nxt = 1'b1;
        end
      end
      if (rxCnt_r == 8'h00) begin
        if (rxOdd_r ^ mode.altMode) cap_nxt = inBit;
      end else begin
        rxSh_nxt = {rxSh_r[6:0], inBit};
        rxWr     = (rxPos[2:0] == 3'h7);                           // [R22]
      end
      rxCnt_nxt = (rxCnt_r == `T1FP_LINE_LAST) ? 8'h00 : rxCnt_r + 8'h01; // [R11]
      if (rxCnt_r == `T1FP_LINE_LAST) begin
        rxOdd_nxt = ~rxOdd_r;
        if (!rxOdd_r) lkOut_nxt = cap_r;                           // [R16]
      end
    end
    fr8_nxt = (rxCnt_r < `T1FP_LINE_HALF);                         // [R11]
    if (viol && bpv_r != `T1FP_BPV_MAX) bpv_nxt = bpv_r + 16'h0001;
    // a clear meeting a new violation keeps that violation
    if (busClr) bpv_nxt = viol ? 16'h0001 : 16'h0000;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      txCnt_r <= 8'h00;
      txOdd_r <= 1'b0;
      txPol_r <= 1'b0;
      outA_r  <= 1'b0;
      outB_r  <= 1'b0;
      hold_r  <= 1'b0;
      rxCnt_r <= 8'h00;
      rxSh_r  <= 8'h00;
      rxOdd_r <= 1'b0;
      cap_r   <= 1'b0;
      lkOut_r <= 1'b0;
      lastB_r <= 1'b0;
      seen_r  <= 1'b0;
      bpv_r   <= 16'h0000;
      fr8_r   <= 1'b0;
    end else begin
      txCnt_r <= txCnt_nxt;
      txOdd_r <= txOdd_nxt;
      txPol_r <= txPol_nxt;
      outA_r  <= outA_nxt;
      outB_r  <= outB_nxt;
      hold_r  <= hold_nxt;
      rxCnt_r <= rxCnt_nxt;
      rxSh_r  <= rxSh_nxt;
      rxOdd_r <= rxOdd_nxt;
      cap_r   <= cap_nxt;
      lkOut_r <= lkOut_nxt;
      lastB_r <= lastB_nxt;
      seen_r  <= seen_nxt;
      bpv_r   <= bpv_nxt;
      fr8_r   <= fr8_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < `T1FP_CHANNELS; i++) begin
        txMem[i]   <= 8'h00;
        rxMem[i]   <= 8'hFF;
        ctl0Mem[i] <= 8'h00;
        ctl1Mem[i] <= 8'h00;
      end
    end else begin
      if (bpWr) begin
        txMem[inCh]   <= diByte;
        ctl0Mem[inCh] <= c0Byte;
        ctl1Mem[inCh] <= c1Byte;
      end
      if (rxWr) rxMem[rxPos[7:3]] <= {rxSh_r[6:0], inBit};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then the answer
  t1fp_bus_t bus_r, bus_nxt;
  logic [31:0] rd_r, rd_nxt;
  always_comb begin
    bus_nxt  = bus_r;
    rd_nxt   = rd_r;
    ctrl_nxt = ctrl_r;
    busClr   = 1'b0;
    case (bus_r)
      BUS_IDLE: begin
        if (avs_read || avs_write) begin
          bus_nxt = BUS_ACK;
          case (avs_address)
            `T1FP_REG_CTRL: rd_nxt = {30'h0, ctrl_r};
            `T1FP_REG_STAT: rd_nxt = {28'h0, rxOdd_r, mode.loop, spare_r, sense_r};
            `T1FP_REG_BPV:  rd_nxt = {16'h0, bpv_r};
            default:        rd_nxt = 32'h0000_0000;
          endcase
        end
      end
      BUS_ACK: begin
        bus_nxt = BUS_IDLE;
        if (avs_write && avs_byteenable[0]) begin
          if (avs_address == `T1FP_REG_CTRL) ctrl_nxt = avs_writedata[1:0];
          busClr = (avs_address == `T1FP_REG_BPV);
        end
      end
      default: bus_nxt = BUS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      bus_r  <= BUS_IDLE;
      rd_r   <= 32'h0000_0000;
      ctrl_r <= `T1FP_CTRL_RESET;
    end else begin
      bus_r  <= bus_nxt;
      rd_r   <= rd_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  assign avs_readdata            = rd_r;
  assign avs_waitrequest         = (bus_r != BUS_ACK);
  assign serial_data_out         = doSh_r[7];
  assign serial_status_out       = soSh_r[7];
  assign line_out_a              = outA_r;
  assign line_out_b              = outB_r;
  assign link_bits_in_clk        = txOdd_r;
  assign link_bits_out           = lkOut_r;
  assign link_bits_out_clk       = rxOdd_r;
  assign recovered_frame_clk_out = fr8_r;
  assign spare_drive_out         = spare_r;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_frame;
    frameStart;
  endsequence
  property p_spareHold;
    $changed(spare_drive_out) |-> $past(frameStart);
  endproperty
  a_spareHold: assert property (p_spareHold) else $error("spare drive moved mid frame"); // [R14]
  property p_spareFollow;
    s_frame |=> spare_drive_out == $past(mcw1_r[`T1FP_SPARE_DRIVE_OUT_BIT]);
  endproperty
  a_spareFollow: assert property (p_spareFollow) else $error("spare drive not from word"); // [R13]
  property p_sense;
    s_frame ##1 (!frameStart)[*2] |-> msw2[`T1FP_XST_BIT] == $past(syncB_r[I_SN], 2);
  endproperty
  a_sense: assert property (p_sense) else $error("sense level misreported"); // [R15]
  property p_div;
    lineEdge && rxCnt_r == `T1FP_LINE_LAST |=> rxCnt_r == 8'h00 ##0 rxOdd_r != $past(rxOdd_r);
  endproperty
  a_div: assert property (p_div) else $error("receive divide not 193"); // [R11]
  property p_loopClk;
    mode.loop && ev.rxFall && !ev.txRise |=> rxCnt_r == $past(rxCnt_r);
  endproperty
  a_loopClk: assert property (p_loopClk) else $error("loopback counted recovered clock"); // [R12]
  property p_ami;
    !(line_out_a && line_out_b);
  endproperty
  a_ami: assert property (p_ami) else $error("both line outputs high"); // [R6]
  property p_txEdge;
    $changed(line_out_a) |-> $past(ev.txRise);
  endproperty
  a_txEdge: assert property (p_txEdge) else $error("line output moved off clock edge"); // [R20]
  property p_linkIn;
    $rose(link_bits_in_clk) |-> hold_r == $past(syncB_r[I_LK]);
  endproperty
  a_linkIn: assert property (p_linkIn) else $error("link bit not taken on rise"); // [R10]
  property p_linkOut;
    $changed(link_bits_out) |-> $rose(link_bits_out_clk);
  endproperty
  a_linkOut: assert property (p_linkOut) else $error("link out changed off rise"); // [R16]
  property p_bpv;
    viol && !busClr && bpv_r != `T1FP_BPV_MAX |=> bpv_r == $past(bpv_r) + 16'h0001;
  endproperty
  a_bpv: assert property (p_bpv) else $error("violation not counted"); // [R7]
endmodule
`default_nettype wire

// [tb/t1_framer_port_interface_tb.sv]
// self-checking bench of the t1 framer pin interface
// assumes the far model drives every pin clock and stream
`include "t1fp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %s expected %0h seen %0h", nm, (e), (g)); end end
module t1_framer_port_interface_tb;
  import t1fp_pkg::*;
  logic                sys_clk = 1'b0, reset_n = 1'b0;
  logic [3:0]          avs_address = 4'h0, avs_byteenable = 4'hF, rxPairs = 4'h0;
  logic                avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0]         avs_writedata = 32'h0, avs_readdata, rd;
  logic                backplane_clk, backplane_frame_pulse_n, serial_data_in, serial_ctrl_in_zero;
  logic                serial_ctrl_in_one, serial_data_out, serial_status_out, line_tx_clk;
  logic                recovered_line_clk, line_in_a_n, line_in_b_n, line_out_a, line_out_b;
  logic                link_bits_in, link_bits_in_clk, link_bits_out, link_bits_out_clk;
  logic                recovered_frame_clk_out, spare_drive_out, spare_sense_in = 1'b0;
  logic                rxRun = 1'b1, linkVal = 1'b0, prevSd = 1'b0;
  logic [15:0]         seed = 16'h4EF5, marks, ones;
  logic [7:0]          amiErr;
  logic [31:0][7:0]    dataSlots = '0, ctrl0Slots = '0, ctrl1Slots = '0, capData, capStat;
  int                  errors = 0, comparisons = 0, cyc = 0, cntTx = 0, cntRx = 0, sdChanges = 0;

  t1fp_port dut (.sys_clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_byteenable, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .backplane_clk, .backplane_frame_pulse_n, .serial_data_in,
    .serial_ctrl_in_zero, .serial_ctrl_in_one, .serial_data_out, .serial_status_out, .line_tx_clk,
    .recovered_line_clk, .line_in_a_n, .line_in_b_n, .line_out_a, .line_out_b, .link_bits_in,
    .link_bits_in_clk, .link_bits_out, .link_bits_out_clk, .recovered_frame_clk_out, .spare_drive_out,
    .spare_sense_in);
  t1fp_far_model far (.rxRun, .rxPairs, .linkVal, .dataSlots, .ctrl0Slots, .ctrl1Slots, .serial_data_out,
    .serial_status_out, .line_out_a, .line_out_b, .link_bits_in_clk, .backplane_clk,
    .backplane_frame_pulse_n, .serial_data_in, .serial_ctrl_in_zero, .serial_ctrl_in_one, .line_tx_clk,
    .recovered_line_clk, .line_in_a_n, .line_in_b_n, .link_bits_in, .capData, .capStat, .marks, .amiErr);
  ////////////////////////////////////////////////////////////////////////////
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge line_tx_clk) cntTx++;
  always @(posedge recovered_line_clk) cntRx++;
  // ceiling well above the roughly 80k cycles the tests need
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (reset_n && spare_drive_out !== prevSd) sdChanges <= sdChanges + 1;
    prevSd <= spare_drive_out;
    if (cyc == 98000) begin
      errors = errors + 1;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // marks in the 192 channel bits of one tx frame
  function automatic logic [15:0] exp_ones(input int k);
    logic [15:0] n;
    n = 16'h0;
    for (int s = 0; s < 32; s++)
      if (s % 4 != 3) n = n + ((k == 2) ? 16'h8 : (k == 1) ? 16'h8 - 16'($countones(dataSlots[s]))
                                                            : 16'($countones(dataSlots[s])));
    return n;
  endfunction
  function automatic logic msig(input int s);
    return (s == 1) ? link_bits_in_clk : (s == 2) ? link_bits_out_clk : recovered_frame_clk_out;
  endfunction
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    // values read at the edge are the ones it samples
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    `CHK("bus answer", 1'b0, avs_waitrequest)
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic win(input int n);
    logic [15:0] m0;
    @(posedge line_tx_clk);
    m0 = marks;
    repeat (n) @(posedge line_tx_clk);
    ones = marks - m0;
  endtask
  // source clock rises over one high phase and one period of a divided output
  task automatic meas(input int s, input int hi, input int per);
    int c[3];
    for (int i = 0; i < 4; i++) begin
      while (msig(s) !== i[0]) @(negedge sys_clk);
      if (i > 0) c[i - 1] = (s == 1 || s == 3) ? cntTx : cntRx;
    end
    if (hi > 0) `CHK("clk high", hi, c[1] - c[0])
    `CHK("clk period", per, c[2] - c[0])
  endtask
  // k 0: random data, 1: invert plus spare drive, 2: idle plus link bit
  task automatic run_cfg(input int k);
    @(posedge sys_clk);
    for (int s = 0; s < 32; s++) begin
      seed = lfsr(seed);
      dataSlots[s] <= seed[7:0];
      ctrl0Slots[s] <= (s == 15) ? {4'h0, k == 1, 3'h0} : (s == 31) ? 8'h00 : {7'h0, k == 2};
      ctrl1Slots[s] <= {7'h0, k == 1};
    end
    spare_sense_in <= seed[8];
    linkVal <= (k == 2);
    // link bit needs a sample and then an odd frame before it shows
    repeat ((k == 2) ? 800 : 210) @(posedge line_tx_clk);
    win((k == 2) ? 386 : 193);
    `CHK("tx marks", (k == 2) ? 16'h2 * exp_ones(2) + 16'h1 : exp_ones(k), ones)
    `CHK("ami", 8'h0, amiErr)
    `CHK("spare drive", k == 1, spare_drive_out)
    `CHK("sense slot", spare_sense_in, capStat[`T1FP_MCW2_SLOT][`T1FP_XST_BIT])
    if (k == 2) `CHK("link out", 1'b0, link_bits_out)
    if (k == 0) begin
      `CHK("bpv slot", 8'h05, capStat[`T1FP_MCW1_SLOT])
      for (int s = 0; s < 32; s++) `CHK("rx slot", (s % 4 == 3) ? `T1FP_EMPTY_SLOT : 8'h00, capData[s])
    end
    $display("test cfg %0d done", k);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge sys_clk);
    `CHK("data out reset", 1'b1, serial_data_out)
    `CHK("wait reset", 1'b1, avs_waitrequest)
    reset_n <= 1'b1;
    bus(1'b0, `T1FP_REG_CTRL, 32'h0, 4'hF);
    `CHK("ctrl reset", 32'h0, rd)
    bus(1'b1, `T1FP_REG_CTRL, 32'h3, 4'hE);
    bus(1'b0, `T1FP_REG_CTRL, 32'h0, 4'hF);
    `CHK("ctrl masked", 32'h0, rd)
    bus(1'b0, 4'hC, 32'h0, 4'hF);
    `CHK("unmapped", 32'h0, rd)
    bus(1'b1, `T1FP_REG_STAT, 32'hFFFFFFFF, 4'hF);
    bus(1'b0, `T1FP_REG_STAT, 32'h0, 4'hF);
    `CHK("stat ro", 3'h0, rd[2:0])
    bus(1'b0, `T1FP_REG_BPV, 32'h0, 4'hF);
    `CHK("bpv reset", 32'h0, rd)
    $display("test regs done");
    rxPairs <= 4'h5;
    fork
      for (int k = 0; k < 3; k++) run_cfg(k);
      begin
        meas(0, 97, 193);
        meas(1, 0, 386);
        meas(2, 0, 386);
      end
    join
    bus(1'b1, `T1FP_REG_CTRL, 32'h2, 4'hF);
    repeat (200) @(posedge line_tx_clk);
    win(386);
    `CHK("alt marks", 16'h2 * exp_ones(2) + 16'h1, ones)
    $display("test alt link done");
    bus(1'b0, `T1FP_REG_BPV, 32'h0, 4'hF);
    `CHK("bpv count", 32'h5, rd)
    bus(1'b1, `T1FP_REG_BPV, 32'h0, 4'hF);
    bus(1'b0, `T1FP_REG_BPV, 32'h0, 4'hF);
    `CHK("bpv clear", 32'h0, rd)
    $display("test bpv done");
    bus(1'b1, `T1FP_REG_CTRL, 32'h1, 4'hF);
    repeat (20) @(posedge line_tx_clk);
    rxRun <= 1'b0;
    meas(3, 97, 193);
    bus(1'b0, `T1FP_REG_STAT, 32'h0, 4'hF);
    `CHK("loop stat", 1'b1, rd[2])
    `CHK("drive changes", 2, sdChanges)
    $display("test loopback done");
    give_verdict();
  end
endmodule
`default_nettype wire

// [tb/t1fp_far_model.sv]
// far side of the pin interface: backplane master, ds1 line ends, link partner
// assumes the bench sets stream contents, rx violation pairs and link level
`timescale 1ns/1ps
`default_nettype none
module t1fp_far_model (
  input  wire logic             rxRun,
  input  wire logic [3:0]       rxPairs,
  input  wire logic             linkVal,
  input  wire logic [31:0][7:0] dataSlots,
  input  wire logic [31:0][7:0] ctrl0Slots,
  input  wire logic [31:0][7:0] ctrl1Slots,
  input  wire logic             serial_data_out,
  input  wire logic             serial_status_out,
  input  wire logic             line_out_a,
  input  wire logic             line_out_b,
  input  wire logic             link_bits_in_clk,
  output logic                  backplane_clk,
  output logic                  backplane_frame_pulse_n,
  output logic                  serial_data_in,
  output logic                  serial_ctrl_in_zero,
  output logic                  serial_ctrl_in_one,
  output logic                  line_tx_clk,
  output logic                  recovered_line_clk,
  output logic                  line_in_a_n,
  output logic                  line_in_b_n,
  output logic                  link_bits_in,
  output logic [31:0][7:0]      capData,
  output logic [31:0][7:0]      capStat,
  output logic [15:0]           marks,
  output logic [7:0]            amiErr
);
  logic [7:0] bc = 8'hFF;
  logic [7:0] nb;
  logic [6:0] shD, shS;
  logic       lastA = 1'b0;
  logic       seen = 1'b0;
  logic [1:0] ph = 2'h0;
  logic       pol = 1'b0;
  logic [3:0] sent = 4'h0;
  initial begin
    backplane_clk = 1'b0;
    line_tx_clk = 1'b0;
    recovered_line_clk = 1'b0;
    {backplane_frame_pulse_n, serial_data_in, serial_ctrl_in_zero, serial_ctrl_in_one} = 4'hF;
    {line_in_a_n, line_in_b_n, link_bits_in} = 3'h6;
    marks = 16'h0;
    amiErr = 8'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  assign nb = bc + 8'h01;
  always #244 backplane_clk = ~backplane_clk;
  // streams change on the fall, away from the sampling rise
  always @(negedge backplane_clk) begin
    bc <= nb;
    serial_data_in      <= dataSlots[nb[7:3]][3'h7 - nb[2:0]];
    serial_ctrl_in_zero <= ctrl0Slots[nb[7:3]][3'h7 - nb[2:0]];
    serial_ctrl_in_one  <= ctrl1Slots[nb[7:3]][3'h7 - nb[2:0]];
  end
  always @(posedge backplane_clk) begin
    backplane_frame_pulse_n <= (bc != 8'hFF);
    shD <= {shD[5:0], serial_data_out};
    shS <= {shS[5:0], serial_status_out};
    if (bc[2:0] == 3'h7) begin
      capData[bc[7:3]] <= {shD, serial_data_out};
      capStat[bc[7:3]] <= {shS, serial_status_out};
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // free running: no phase lock to the backplane clock here
  always #324 line_tx_clk = ~line_tx_clk;
  always @(negedge line_tx_clk) begin
    if (line_out_a | line_out_b) begin
      marks  <= marks + 16'h1;
      amiErr <= amiErr + {7'h0, (line_out_a & line_out_b) | (seen & (line_out_a == lastA))};
      lastA  <= line_out_a;
      seen   <= 1'b1;
    end
  end
  // recovered clock stands still while the line is down
  always #324 if (rxRun) recovered_line_clk = ~recovered_line_clk;
  // pairs of same-polarity marks, a space, then the other polarity
  always @(posedge recovered_line_clk) begin
    line_in_a_n <= !((sent < rxPairs) && ph != 2'h2 && !pol);
    line_in_b_n <= !((sent < rxPairs) && ph != 2'h2 && pol);
    if (sent < rxPairs) begin
      ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      if (ph == 2'h2) begin
        pol  <= ~pol;
        sent <= sent + 4'h1;
      end
    end
  end
  always @(negedge link_bits_in_clk) link_bits_in <= linkVal;
endmodule
`default_nettype wire
